/* File: bench/sbtac_cpu_model.sv */
// Purpose: processor-side APB master model for the timer core
// Assumes: one caller at a time, signals change after rising edges
// Notes: 16-bit helpers keep byte order and never interleave
`timescale 1ns/100ps
`default_nettype none
module sbtac_cpu_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // ----------------------------------------------------------------
  // Single byte transfer
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~{24'h000000, d};
  endtask
  // ----------------------------------------------------------------
  // Two-byte accesses, kept whole
  // ----------------------------------------------------------------
  task automatic wr16(input logic [7:0] lo, input logic [7:0] hi,
      input logic [15:0] v);
    logic [31:0] q;
    logic e;
    xfer(1'b1, hi, v[15:8], q, e);
    xfer(1'b1, lo, v[7:0], q, e);
  endtask
  task automatic rd16(input logic [7:0] lo, input logic [7:0] hi,
      output logic [15:0] v);
    logic [31:0] q;
    logic e;
    xfer(1'b0, lo, 8'h00, q, e);
    v[7:0] = q[7:0];
    xfer(1'b0, hi, 8'h00, q, e);
    v[15:8] = q[7:0];
  endtask
endmodule // sbtac_cpu_model
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for the timer access core
// Assumes: counter stopped whenever values are compared
// Notes: ends through results on completion or timeout
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sbtac_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic ext_count_pin, capture_input_pin, comparator_out, e;
  logic flag_clear_on_ack, wave_out_a, wave_out_b;
  logic [2:0] clock_select;
  logic [3:0] irq_ack, irq_req;
  logic [15:0] v;
  int mismatches, checks, cyc;
  sbtac_core #(.NCAN_LEN(4)) sbtac_core_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_pin(ext_count_pin), .capture_input_pin(capture_input_pin),
    .comparator_out(comparator_out), .clock_select(clock_select),
    .flag_clear_on_ack(flag_clear_on_ack), .irq_ack(irq_ack),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .irq_req(irq_req));
  sbtac_cpu_model sbtac_cpu_model_i (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sbtac_cpu_model_i.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    sbtac_cpu_model_i.xfer(1'b0, a, 8'h00, q, e);
    chk(q, {24'h000000, x});
  endtask
  task automatic pulse(input logic [2:0] cs, input int n);
    @(posedge pclk);
    clock_select <= cs;
    repeat (n) begin
      repeat (4) @(posedge pclk);
      ext_count_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_count_pin <= 1'b0;
    end
    repeat (8) @(posedge pclk);
    clock_select <= SBTAC_CS_OFF;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    ext_count_pin = 1'b0;
    capture_input_pin = 1'b0;
    comparator_out = 1'b0;
    clock_select = SBTAC_CS_OFF;
    flag_clear_on_ack = 1'b0;
    irq_ack = 4'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(SBTAC_CTRL_A, SBTAC_RST8);
    rd(SBTAC_CTRL_B, SBTAC_RST8);
    rd(SBTAC_FLAG, SBTAC_RST8);
    rd(SBTAC_MASK, SBTAC_RST8);
    rd(SBTAC_CNT_L, SBTAC_BOTTOM[7:0]);
    wr(SBTAC_CNT_H, 8'h12);
    wr(SBTAC_CNT_L, 8'h34);
    repeat (20) @(posedge pclk);
    rd(SBTAC_CNT_L, 8'h34);
    rd(SBTAC_CNT_H, 8'h12);
    wr(SBTAC_CNT_H, 8'h56);
    rd(SBTAC_CNT_H, 8'h56);
    rd(SBTAC_CNT_L, 8'h34);
    rd(SBTAC_CNT_H, 8'h12);
    wr(SBTAC_CNT_H, 8'hAB);
    wr(SBTAC_CMPA_L, 8'hCD);
    rd(SBTAC_CNT_L, 8'h34);
    rd(SBTAC_CMPA_H, 8'hAB);
    rd(SBTAC_CMPA_L, 8'hCD);
    rd(SBTAC_CNT_H, 8'h12);
    wr(SBTAC_CTRL_A, 8'hC3);
    rd(SBTAC_CTRL_A, 8'h03);
    wr(SBTAC_CTRL_A, 8'h00);
    wr(SBTAC_CTRL_B, 8'h18);
    rd(SBTAC_CTRL_B, 8'h18);
    wr(SBTAC_CTRL_B, 8'h00);
    sbtac_cpu_model_i.xfer(1'b0, 8'h30, 8'h00, q, e);
    chk(q, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
    // Compare match, masking and acknowledge
    sbtac_cpu_model_i.wr16(SBTAC_CNT_L, SBTAC_CNT_H, 16'h0000);
    sbtac_cpu_model_i.wr16(SBTAC_CMPB_L, SBTAC_CMPB_H, 16'h0005);
    wr(SBTAC_FLAG, 8'h0F);
    wr(SBTAC_MASK, 8'h0F);
    clock_select <= 3'h1;
    repeat (30) @(posedge pclk);
    clock_select <= SBTAC_CS_OFF;
    rd(SBTAC_FLAG, 8'h02);
    chk({28'h0, irq_req}, 32'h2);
    wr(SBTAC_MASK, 8'h0D);
    repeat (2) @(posedge pclk);
    chk({28'h0, irq_req}, 32'h0);
    flag_clear_on_ack <= 1'b1;
    irq_ack <= 4'h2;
    @(posedge pclk);
    irq_ack <= 4'h0;
    rd(SBTAC_FLAG, 8'h00);
    flag_clear_on_ack <= 1'b0;
    // Force bits toggle both outputs outside PWM and read back zero
    v[1:0] = {wave_out_b, wave_out_a};
    wr(SBTAC_CTRL_A, 8'hC0);
    @(posedge pclk);
    chk({30'h0, wave_out_b, wave_out_a}, {30'h0, ~v[1:0]});
    rd(SBTAC_CTRL_A, 8'h00);
    // External clock on both edges
    sbtac_cpu_model_i.wr16(SBTAC_CNT_L, SBTAC_CNT_H, 16'h0100);
    pulse(SBTAC_CS_EXT_RISE, 3);
    pulse(SBTAC_CS_EXT_FALL, 3);
    sbtac_cpu_model_i.rd16(SBTAC_CNT_L, SBTAC_CNT_H, v);
    chk({16'h0, v}, 32'h0106);
    // Capture from pin, filter, comparator
    wr(SBTAC_CTRL_B, 8'h40);
    wr(SBTAC_FLAG, 8'h0F);
    capture_input_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    sbtac_cpu_model_i.rd16(SBTAC_CAP_L, SBTAC_CAP_H, v);
    chk({16'h0, v}, 32'h0106);
    rd(SBTAC_FLAG, 8'h08);
    capture_input_pin <= 1'b0;
    sbtac_cpu_model_i.wr16(SBTAC_CNT_L, SBTAC_CNT_H, 16'h0200);
    wr(SBTAC_CTRL_B, 8'hC0);
    wr(SBTAC_FLAG, 8'h0F);
    capture_input_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    capture_input_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    rd(SBTAC_FLAG, 8'h00);
    capture_input_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(SBTAC_FLAG, 8'h08);
    sbtac_cpu_model_i.rd16(SBTAC_CAP_L, SBTAC_CAP_H, v);
    chk({16'h0, v}, 32'h0200);
    sbtac_cpu_model_i.wr16(SBTAC_CNT_L, SBTAC_CNT_H, 16'h0300);
    wr(SBTAC_CTRL_B, 8'h60);
    wr(SBTAC_FLAG, 8'h0F);
    comparator_out <= 1'b1;
    repeat (10) @(posedge pclk);
    sbtac_cpu_model_i.rd16(SBTAC_CAP_L, SBTAC_CAP_H, v);
    chk({16'h0, v}, 32'h0300);
    // Compare A as TOP keeps the count small
    wr(SBTAC_CTRL_B, 8'h08);
    sbtac_cpu_model_i.wr16(SBTAC_CMPA_L, SBTAC_CMPA_H, 16'h0003);
    sbtac_cpu_model_i.wr16(SBTAC_CNT_L, SBTAC_CNT_H, 16'h0000);
    clock_select <= 3'h1;
    repeat (40) @(posedge pclk);
    clock_select <= SBTAC_CS_OFF;
    sbtac_cpu_model_i.rd16(SBTAC_CNT_L, SBTAC_CNT_H, v);
    chk({31'h0, v > 16'h0003}, 32'h0);
    results();
  end
endmodule // tb_top
`default_nettype wire

/* File: common/sbtac_pkg.sv */
// Purpose: constants for the 16-bit timer access core
// Assumes: APB slave, one word per register, data in low byte
// Notes: offsets are byte addresses
package sbtac_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SBTAC_CNT_L = 8'h00;
  localparam logic [7:0] SBTAC_CNT_H = 8'h04;
  localparam logic [7:0] SBTAC_CMPA_L = 8'h08;
  localparam logic [7:0] SBTAC_CMPA_H = 8'h0C;
  localparam logic [7:0] SBTAC_CMPB_L = 8'h10;
  localparam logic [7:0] SBTAC_CMPB_H = 8'h14;
  localparam logic [7:0] SBTAC_CAP_L = 8'h18;
  localparam logic [7:0] SBTAC_CAP_H = 8'h1C;
  localparam logic [7:0] SBTAC_CTRL_A = 8'h20;
  localparam logic [7:0] SBTAC_CTRL_B = 8'h24;
  localparam logic [7:0] SBTAC_FLAG = 8'h28;
  localparam logic [7:0] SBTAC_MASK = 8'h2C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SBTAC_FA_FORCE_A = 7;
  localparam int SBTAC_FA_FORCE_B = 6;
  localparam int SBTAC_FA_WGM1 = 1;
  localparam int SBTAC_FA_WGM0 = 0;
  localparam int SBTAC_FB_NCAN = 7;
  localparam int SBTAC_FB_CEDGE = 6;
  localparam int SBTAC_FB_CSRC = 5;
  localparam int SBTAC_FB_WGM3 = 4;
  localparam int SBTAC_FB_WGM2 = 3;
  localparam int SBTAC_FL_CAP = 3;
  localparam int SBTAC_FL_MA = 2;
  localparam int SBTAC_FL_MB = 1;
  localparam int SBTAC_FL_OVF = 0;
  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [15:0] SBTAC_BOTTOM = 16'h0000;
  localparam logic [15:0] SBTAC_MAX = 16'hFFFF;
  localparam logic [15:0] SBTAC_TOP8 = 16'h00FF;
  localparam logic [15:0] SBTAC_TOP9 = 16'h01FF;
  localparam logic [15:0] SBTAC_TOP10 = 16'h03FF;
  localparam logic [7:0] SBTAC_RST8 = 8'h00;
  localparam logic [15:0] SBTAC_RST16 = 16'h0000;
  localparam logic [2:0] SBTAC_CS_OFF = 3'h0;
  localparam logic [2:0] SBTAC_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] SBTAC_CS_EXT_RISE = 3'h7;
  localparam int SBTAC_NCAN_LEN = 4;
endpackage

/* File: logic/sbtac_core.sv */
// Purpose: 16-bit timer register access core with APB slave
// Assumes: pclk 250 MHz, presetn async active low, 8-bit data in low lanes
// Notes: one shared staging byte serves all 16-bit registers
//
// Functional notes
// - One 8-bit high-byte staging register shared by all 16-bit registers.
// - Low-byte write loads staged high byte and low byte together.
// - Counter and capture low-byte reads copy register high byte into staging same cycle.
// - Only low-byte access transfers; high-byte access touches staging only.
// - Compare high-byte reads return directly, staging untouched.
// - Two control registers are 8-bit read/write; control A force bits read back as zero.
// - Counter holds still while clock selection picks no source.
// - Tick from prescaler or external pin edge chosen by selection.
// - Both buffered compare registers compared with counter always.
// - Compare match sets that channel's match flag.
// - Compare results drive PWM or frequency outputs per channel.
// - Capture event from pin or comparator copies counter to capture.
// - Capture path has a digital noise filter.
// - TOP is a fixed value, compare A or capture register.
// - Compare A as PWM TOP disables output A, TOP double buffered.
// - BOTTOM is zero, MAX is all ones.
// - Capture register usable as fixed TOP freeing compare A.
// - Four flags in flag register, individually masked.
// - Control A holds force bits, control B holds mode bits 3 and 2.
// - Processor counter write beats clear or count same cycle.
`timescale 1ns/100ps
`default_nettype none
module sbtac_core
  import sbtac_pkg::*;
#(
  parameter int NCAN_LEN = SBTAC_NCAN_LEN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_pin,
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  input wire logic [2:0] clock_select,
  input wire logic flag_clear_on_ack,
  input wire logic [3:0] irq_ack,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic [3:0] irq_req
);
  initial begin
    if (NCAN_LEN < 2 || NCAN_LEN > 8) begin
      $error("NCAN_LEN out of range");
    end
  end
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic acc, wr, rd, setup_rd, mapped;
  logic [7:0] wb;
  assign acc = psel & penable;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign wb = pwdata[7:0];
  always_comb begin
    if (paddr == SBTAC_CNT_L || paddr == SBTAC_CNT_H) mapped = 1'b1;
    else if (paddr == SBTAC_CMPA_L || paddr == SBTAC_CMPA_H) mapped = 1'b1;
    else if (paddr == SBTAC_CMPB_L || paddr == SBTAC_CMPB_H) mapped = 1'b1;
    else if (paddr == SBTAC_CAP_L || paddr == SBTAC_CAP_H) mapped = 1'b1;
    else if (paddr == SBTAC_CTRL_A || paddr == SBTAC_CTRL_B) mapped = 1'b1;
    else if (paddr == SBTAC_FLAG || paddr == SBTAC_MASK) mapped = 1'b1;
    else mapped = 1'b0;
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] stage_r;
  logic [15:0] count_value_reg, compare_a_reg, compare_b_reg;
  logic [15:0] capture_value_reg, cmpa_buf_r, cmpb_buf_r;
  logic [7:0] control_a_reg, control_b_reg;
  logic [3:0] timer_flag_reg, timer_mask_reg;
  logic [3:0] wgm;
  logic [15:0] top;
  logic pwm_mode, top_is_a, top_is_cap;
  assign wgm = {control_b_reg[SBTAC_FB_WGM3], control_b_reg[SBTAC_FB_WGM2],
                control_a_reg[SBTAC_FA_WGM1], control_a_reg[SBTAC_FA_WGM0]};
  assign pwm_mode = (wgm != 4'h0) && (wgm != 4'h4) && (wgm != 4'hC);
  assign top_is_a = (wgm == 4'h4) || (wgm == 4'h9) || (wgm == 4'hB)
                    || (wgm == 4'hF);
  assign top_is_cap = (wgm == 4'h8) || (wgm == 4'hA) || (wgm == 4'hC)
                      || (wgm == 4'hE);
  always_comb begin
    if (top_is_a) top = compare_a_reg;
    else if (top_is_cap) top = capture_value_reg;
    else if (wgm[1:0] == 2'h1) top = SBTAC_TOP8;
    else if (wgm[1:0] == 2'h2) top = SBTAC_TOP9;
    else if (wgm[1:0] == 2'h3) top = SBTAC_TOP10;
    else top = SBTAC_MAX;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_r <= SBTAC_RST8;
    end else if (wr && (paddr == SBTAC_CNT_H || paddr == SBTAC_CMPA_H ||
                 paddr == SBTAC_CMPB_H || paddr == SBTAC_CAP_H)) begin
      stage_r <= wb;
    end else if (setup_rd && paddr == SBTAC_CNT_L) begin
      stage_r <= count_value_reg[15:8];
    end else if (setup_rd && paddr == SBTAC_CAP_L) begin
      stage_r <= capture_value_reg[15:8];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_a_reg <= SBTAC_RST8;
      control_b_reg <= SBTAC_RST8;
      timer_mask_reg <= 4'h0;
    end else begin
      if (wr && paddr == SBTAC_CTRL_A) control_a_reg <= wb;
      if (wr && paddr == SBTAC_CTRL_B) control_b_reg <= wb;
      if (wr && paddr == SBTAC_MASK) timer_mask_reg <= wb[3:0];
    end
  end
  // ----------------------------------------------------------------
  // Tick selection
  // ----------------------------------------------------------------
  logic [9:0] presc_r;
  logic ext_s1_r, ext_s2_r, ext_s3_r, tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= 10'h000;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      presc_r <= presc_r + 10'h001;
      ext_s1_r <= ext_count_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  always_comb begin
    case (clock_select)
      3'h1: tick = 1'b1;
      3'h2: tick = (presc_r[2:0] == 3'h7);
      3'h3: tick = (presc_r[5:0] == 6'h3F);
      3'h4: tick = (presc_r[7:0] == 8'hFF);
      3'h5: tick = (presc_r == 10'h3FF);
      SBTAC_CS_EXT_FALL: tick = ext_s3_r & ~ext_s2_r;
      SBTAC_CS_EXT_RISE: tick = ~ext_s3_r & ext_s2_r;
      default: tick = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------
  // Counter, compare buffers
  // ----------------------------------------------------------------
  logic at_top, at_bottom, at_max;
  assign at_top = (count_value_reg == top);
  assign at_bottom = (count_value_reg == SBTAC_BOTTOM);
  assign at_max = (count_value_reg == SBTAC_MAX);
  logic ovf_ev;
  assign ovf_ev = tick && (pwm_mode ? at_top : (at_max || at_top));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_reg <= SBTAC_RST16;
    end else if (wr && paddr == SBTAC_CNT_L) begin
      count_value_reg <= {stage_r, wb};
    end else if (tick) begin
      if (at_top) count_value_reg <= SBTAC_BOTTOM;
      else count_value_reg <= count_value_reg + 16'h0001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_buf_r <= SBTAC_RST16;
      cmpb_buf_r <= SBTAC_RST16;
      compare_a_reg <= SBTAC_RST16;
      compare_b_reg <= SBTAC_RST16;
    end else begin
      if (wr && paddr == SBTAC_CMPA_L) cmpa_buf_r <= {stage_r, wb};
      if (wr && paddr == SBTAC_CMPB_L) cmpb_buf_r <= {stage_r, wb};
      if (!pwm_mode || (tick && at_top)) begin
        compare_a_reg <= cmpa_buf_r;
        compare_b_reg <= cmpb_buf_r;
      end
    end
  end
  // ----------------------------------------------------------------
  // Capture with noise filter
  // ----------------------------------------------------------------
  logic cap_src, cap_s1_r, cap_s2_r, filt_r, filt_d_r, cap_ev;
  logic [NCAN_LEN-1:0] hist_r;
  assign cap_src = control_b_reg[SBTAC_FB_CSRC] ? comparator_out
                                                : capture_input_pin;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_s1_r <= 1'b0;
      cap_s2_r <= 1'b0;
      hist_r <= '0;
      filt_r <= 1'b0;
      filt_d_r <= 1'b0;
    end else begin
      cap_s1_r <= cap_src;
      cap_s2_r <= cap_s1_r;
      hist_r <= {hist_r[NCAN_LEN-2:0], cap_s2_r};
      if (!control_b_reg[SBTAC_FB_NCAN]) filt_r <= cap_s2_r;
      else if (&{hist_r, cap_s2_r}) filt_r <= 1'b1;
      else if (~|{hist_r, cap_s2_r}) filt_r <= 1'b0;
      filt_d_r <= filt_r;
    end
  end
  assign cap_ev = control_b_reg[SBTAC_FB_CEDGE] ? (filt_r & ~filt_d_r)
                                                : (~filt_r & filt_d_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_value_reg <= SBTAC_RST16;
    end else if (top_is_cap) begin
      if (wr && paddr == SBTAC_CAP_L) capture_value_reg <= {stage_r, wb};
    end else if (cap_ev) begin
      capture_value_reg <= count_value_reg;
    end
  end
  // ----------------------------------------------------------------
  // Flags and outputs
  // ----------------------------------------------------------------
  logic match_a, match_b, force_a, force_b;
  logic [3:0] set_v, clr_v;
  assign match_a = tick && (count_value_reg == compare_a_reg);
  assign match_b = tick && (count_value_reg == compare_b_reg);
  assign force_a = wr && paddr == SBTAC_CTRL_A && wb[SBTAC_FA_FORCE_A];
  assign force_b = wr && paddr == SBTAC_CTRL_A && wb[SBTAC_FA_FORCE_B];
  assign set_v = {cap_ev && !top_is_cap, match_a, match_b, ovf_ev};
  assign clr_v = ((wr && paddr == SBTAC_FLAG) ? wb[3:0] : 4'h0)
                 | (flag_clear_on_ack ? irq_ack : 4'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_flag_reg <= 4'h0;
    end else begin
      timer_flag_reg <= (timer_flag_reg & ~clr_v) | set_v;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 4'h0;
    end else begin
      irq_req <= timer_flag_reg & timer_mask_reg;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      if (pwm_mode) begin
        if (top_is_a) wave_out_a <= 1'b0;
        else wave_out_a <= (count_value_reg < compare_a_reg);
        wave_out_b <= (count_value_reg < compare_b_reg);
      end else begin
        if (match_a || force_a) wave_out_a <= ~wave_out_a;
        if (match_b || force_b) wave_out_b <= ~wave_out_b;
      end
    end
  end
  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rmux;
  always_comb begin
    if (paddr == SBTAC_CNT_L) rmux = count_value_reg[7:0];
    else if (paddr == SBTAC_CMPA_L) rmux = compare_a_reg[7:0];
    else if (paddr == SBTAC_CMPA_H) rmux = compare_a_reg[15:8];
    else if (paddr == SBTAC_CMPB_L) rmux = compare_b_reg[7:0];
    else if (paddr == SBTAC_CMPB_H) rmux = compare_b_reg[15:8];
    else if (paddr == SBTAC_CAP_L) rmux = capture_value_reg[7:0];
    else if (paddr == SBTAC_CNT_H || paddr == SBTAC_CAP_H) rmux = stage_r;
    else if (paddr == SBTAC_CTRL_A) rmux = {2'h0, control_a_reg[5:0]};
    else if (paddr == SBTAC_CTRL_B) rmux = control_b_reg;
    else if (paddr == SBTAC_FLAG) rmux = {4'h0, timer_flag_reg};
    else if (paddr == SBTAC_MASK) rmux = {4'h0, timer_mask_reg};
    else rmux = 8'h00;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= (psel & ~penable & ~pwrite) ? {24'h000000, rmux} : prdata;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    (clock_select == SBTAC_CS_OFF) && !(wr && paddr == SBTAC_CNT_L)
    |=> $stable(count_value_reg);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved");
  property p_cnt_wr;
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == SBTAC_CNT_L
    |=> count_value_reg == {$past(stage_r), $past(wb)};
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("bad write");
  property p_rd_stage;
    @(posedge pclk) disable iff (!presetn)
    setup_rd && paddr == SBTAC_CNT_L
    |=> stage_r == $past(count_value_reg[15:8]);
  endproperty
  a_rd_stage: assert property (p_rd_stage) else $error("stage miss");
  property p_cmp_rd;
    @(posedge pclk) disable iff (!presetn)
    rd && paddr == SBTAC_CMPA_H |=> $stable(stage_r);
  endproperty
  a_cmp_rd: assert property (p_cmp_rd) else $error("stage hit");
  property p_hi_only;
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == SBTAC_CNT_H |=> $stable(count_value_reg) || $past(tick);
  endproperty
  a_hi_only: assert property (p_hi_only) else $error("hi moved");
  property p_flag_a;
    @(posedge pclk) disable iff (!presetn)
    match_a |=> timer_flag_reg[SBTAC_FL_MA];
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("no flag a");
  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    timer_flag_reg[SBTAC_FL_OVF] && timer_mask_reg[SBTAC_FL_OVF]
    |=> irq_req[SBTAC_FL_OVF];
  endproperty
  a_irq: assert property (p_irq) else $error("no irq");
  property p_cap;
    @(posedge pclk) disable iff (!presetn)
    cap_ev && !top_is_cap |=> capture_value_reg == $past(count_value_reg);
  endproperty
  a_cap: assert property (p_cap) else $error("no capture");
endmodule // sbtac_core
`default_nettype wire
